// *** logic/swp_status_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module swp_status_ctrl
   import swp_pkg::*;
#(
   parameter int WRITE_CYCLES = STATUS_WRITE_CYCLES,
   parameter int BLK_W        = 9
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             cs_n_i,
   input  wire logic             sclk_i,
   input  wire logic             data0_i,
   input  wire logic             write_protect_n_or_data2_i,
   input  wire logic             four_wire_command_mode_i,
   input  wire logic             double_edge_i,
   input  wire logic [2:0]       read_kind_i,
   input  wire logic             pe_req_i,
   input  wire logic [BLK_W-1:0] pe_block_i,
   output logic      [7:0]       status_reg_o,
   output logic      [7:0]       config_reg_o,
   output logic                  hardware_protect_state_o,
   output logic                  software_protect_state_o,
   output logic                  shared_pins_are_data_o,
   output logic      [3:0]       dummy_clocks_o,
   output logic      [6:0]       drive_ohms_o,
   output logic                  pe_refused_o,
   output logic                  write_status_cmd_rejected_o
);
   // ----------------------------------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------------------------------
   logic [3:0] pins_s;
   logic       cs_n_s, sclk_s, data_s, wp_n_s;
   logic       cs_d_ff, sclk_d_ff;

   swp_sync #(.WIDTH(4)) u_sync (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({cs_n_i, sclk_i, data0_i, write_protect_n_or_data2_i}),
      .sync_o    (pins_s)
   );
   assign {cs_n_s, sclk_s, data_s, wp_n_s} = pins_s;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_d_ff   <= 1'b1;
         sclk_d_ff <= 1'b1;
      end else begin
         cs_d_ff   <= cs_n_s;
         sclk_d_ff <= sclk_s;
      end
   end

   logic sclk_rise, cs_fall, cs_rise;
   assign sclk_rise = sclk_s & ~sclk_d_ff;
   assign cs_fall   = cs_d_ff & ~cs_n_s;
   assign cs_rise   = ~cs_d_ff & cs_n_s;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [3:0] dummy_of(input logic [2:0] kind,
                                           input logic [1:0] dc,
                                           input logic       dtr);
      logic [3:0] d;
      d = DUMMY_8;
      if (kind == RK_DUAL_IO) begin
         d = dc[0] ? DUMMY_8 : DUMMY_4;
      end else if (kind == RK_QUAD_IO) begin
         case (dc)
            2'b00:   d = DUMMY_6;
            2'b01:   d = dtr ? DUMMY_6 : DUMMY_4;
            2'b10:   d = DUMMY_8;
            default: d = DUMMY_10;
         endcase
      end
      return d;
   endfunction

   function automatic logic [6:0] ohms_of(input logic [1:0] ds);
      logic [6:0] o;
      case (ds)
         2'b00:   o = OHM_DS00;
         2'b01:   o = OHM_DS01;
         2'b10:   o = OHM_DS10;
         default: o = OHM_DS11;
      endcase
      return o;
   endfunction

   // level n protects 2^(n-1) blocks, at most 2^BLK_W, from the top or bottom end
   function automatic logic prot_hit(input logic [3:0]       lvl,
                                     input logic             tb,
                                     input logic [BLK_W-1:0] blk);
      logic [BLK_W:0] n;
      logic [BLK_W:0] b;
      n = '0;
      b = {1'b0, blk};
      if (lvl != 4'h0) begin
         n = (int'(lvl) > BLK_W) ? (BLK_W+1)'(1) << BLK_W
                                 : (BLK_W+1)'(1) << (lvl - 4'h1);
      end
      if (tb) begin
         return b < n;
      end
      return b >= ((BLK_W+1)'(1) << BLK_W) - n;
   endfunction

   // ----------------------------------------------------------------
   // frame capture
   // ----------------------------------------------------------------
   swp_frame_t  frame_ff, nxt_frame;
   logic [5:0]  bits_ff, nxt_bits;
   logic [23:0] shift_ff, nxt_shift;
   logic [7:0]  op_ff, nxt_op;

   always_comb begin
      nxt_frame = frame_ff;
      nxt_bits  = bits_ff;
      nxt_shift = shift_ff;
      nxt_op    = op_ff;
      case (frame_ff)
         FR_IDLE: begin
            if (cs_fall) begin
               nxt_frame = FR_SHIFT;
               nxt_bits  = '0;
               nxt_shift = '0;
            end
         end
         FR_SHIFT: begin
            if (cs_rise) begin
               nxt_frame = FR_IDLE;
            end else if (sclk_rise) begin
               nxt_shift = {shift_ff[22:0], data_s};
               if (bits_ff != BITS_SAT) begin
                  nxt_bits = bits_ff + 6'h01;
               end
               if (bits_ff == BITS_OPCODE - 6'h01) begin
                  nxt_op = {shift_ff[6:0], data_s};
               end
            end
         end
         default: nxt_frame = FR_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_ff <= FR_IDLE;
         bits_ff  <= '0;
         shift_ff <= '0;
         op_ff    <= '0;
      end else begin
         frame_ff <= nxt_frame;
         bits_ff  <= nxt_bits;
         shift_ff <= nxt_shift;
         op_ff    <= nxt_op;
      end
   end

   // ----------------------------------------------------------------
   // protection state
   // ----------------------------------------------------------------
   logic lock_ff, quad_ff, wel_ff, busy, wr_done, wr_start;
   logic hw_prot;

   assign hw_prot = lock_ff & ~wp_n_s
                    & ~quad_ff & ~four_wire_command_mode_i;

   // ----------------------------------------------------------------
   // command decode at chip-select rise
   // ----------------------------------------------------------------
   logic frame_end, op_only, is_write_status_cmd, write_status_cmd_ok, write_status_cmd_bad;
   assign frame_end = (frame_ff == FR_SHIFT) & cs_rise;
   assign op_only   = frame_end & (bits_ff == BITS_OPCODE);
   assign is_write_status_cmd   = frame_end & (op_ff == OP_WRITE_STATUS) & (bits_ff >= BITS_ONE_REG);
   assign write_status_cmd_ok   = is_write_status_cmd
                      & ((bits_ff == BITS_ONE_REG)
                         | (bits_ff == BITS_TWO_REG))
                      & wel_ff
                      & ~busy
                      & ~hw_prot;
   assign write_status_cmd_bad  = is_write_status_cmd & ~write_status_cmd_ok;
   assign wr_start  = write_status_cmd_ok;

   swp_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .start_i (wr_start),
      .busy_o  (busy),
      .done_o  (wr_done)
   );

   // ----------------------------------------------------------------
   // status and configuration registers
   // ----------------------------------------------------------------
   logic [3:0] lvl_ff, nxt_lvl;
   logic [1:0] dc_ff, nxt_dc, ds_ff, nxt_ds;
   logic       a4_ff, nxt_a4, pbe_ff, nxt_pbe, tb_ff, nxt_tb;
   logic       nxt_lock, nxt_quad, nxt_wel, nxt_rej;
   logic [7:0] pend_sr_ff, nxt_pend_sr, pend_cr_ff, nxt_pend_cr;
   logic       pend_cr_en_ff, nxt_pend_cr_en, rej_ff;

   always_comb begin
      nxt_lock       = lock_ff;
      nxt_quad       = quad_ff;
      nxt_lvl        = lvl_ff;
      nxt_wel        = wel_ff;
      nxt_dc         = dc_ff;
      nxt_a4         = a4_ff;
      nxt_pbe        = pbe_ff;
      nxt_tb         = tb_ff;
      nxt_ds         = ds_ff;
      nxt_pend_sr    = pend_sr_ff;
      nxt_pend_cr    = pend_cr_ff;
      nxt_pend_cr_en = pend_cr_en_ff;
      nxt_rej        = write_status_cmd_bad;
      if (op_only & ~busy) begin
         if (op_ff == OP_WRITE_ENABLE) begin
            nxt_wel = 1'b1;
         end else if (op_ff == OP_WRITE_DISABLE) begin
            nxt_wel = 1'b0;
         end else if (op_ff == OP_ADDR4_ENTER) begin
            nxt_a4 = 1'b1;
         end else if (op_ff == OP_ADDR4_EXIT) begin
            nxt_a4 = 1'b0;
         end
      end
      if (write_status_cmd_ok) begin
         nxt_pend_cr_en = (bits_ff == BITS_TWO_REG);
         nxt_pend_sr    = (bits_ff == BITS_TWO_REG) ? shift_ff[15:8] : shift_ff[7:0];
         nxt_pend_cr    = shift_ff[7:0];
      end
      if (wr_done) begin
         nxt_lock = pend_sr_ff[SR_LOCK];
         nxt_quad = pend_sr_ff[SR_QUAD];
         nxt_lvl  = pend_sr_ff[SR_LVL_HI:SR_LVL_LO];
         nxt_wel  = 1'b0;
         if (pend_cr_en_ff) begin
            nxt_dc  = pend_cr_ff[CR_DC_HI:CR_DC_LO];
            nxt_pbe = pend_cr_ff[CR_PBE];
            nxt_tb  = tb_ff | pend_cr_ff[CR_TB];
            nxt_ds  = pend_cr_ff[CR_DS_HI:CR_DS_LO];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_ff       <= 1'b0;
         quad_ff       <= 1'b0;
         lvl_ff        <= RST_LEVEL;
         wel_ff        <= 1'b0;
         dc_ff         <= RST_DC;
         a4_ff         <= 1'b0;
         pbe_ff        <= 1'b0;
         tb_ff         <= 1'b0;
         ds_ff         <= RST_DS;
         pend_sr_ff    <= '0;
         pend_cr_ff    <= '0;
         pend_cr_en_ff <= 1'b0;
         rej_ff        <= 1'b0;
      end else begin
         lock_ff       <= nxt_lock;
         quad_ff       <= nxt_quad;
         lvl_ff        <= nxt_lvl;
         wel_ff        <= nxt_wel;
         dc_ff         <= nxt_dc;
         a4_ff         <= nxt_a4;
         pbe_ff        <= nxt_pbe;
         tb_ff         <= nxt_tb;
         ds_ff         <= nxt_ds;
         pend_sr_ff    <= nxt_pend_sr;
         pend_cr_ff    <= nxt_pend_cr;
         pend_cr_en_ff <= nxt_pend_cr_en;
         rej_ff        <= nxt_rej;
      end
   end

   // ----------------------------------------------------------------
   // registered data outputs
   // ----------------------------------------------------------------
   logic [3:0] dum_ff, nxt_dum;
   logic [6:0] ohm_ff, nxt_ohm;
   logic       pe_ref_ff, nxt_pe_ref;

   always_comb begin
      nxt_dum    = dummy_of(read_kind_i, dc_ff, double_edge_i);
      nxt_ohm    = ohms_of(ds_ff);
      nxt_pe_ref = pe_req_i & prot_hit(lvl_ff, tb_ff, pe_block_i);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dum_ff    <= DUMMY_8;
         ohm_ff    <= OHM_DS00;
         pe_ref_ff <= 1'b0;
      end else begin
         dum_ff    <= nxt_dum;
         ohm_ff    <= nxt_ohm;
         pe_ref_ff <= nxt_pe_ref;
      end
   end

   assign status_reg_o = {lock_ff, quad_ff, lvl_ff, wel_ff, busy};
   assign config_reg_o = {dc_ff, a4_ff, pbe_ff, tb_ff, 1'b0, ds_ff};
   assign hardware_protect_state_o = hw_prot;
   assign software_protect_state_o = ~hw_prot;
   assign shared_pins_are_data_o   = quad_ff;
   assign dummy_clocks_o           = dum_ff;
   assign drive_ohms_o             = ohm_ff;
   assign pe_refused_o             = pe_ref_ff;
   assign write_status_cmd_rejected_o          = rej_ff;
endmodule
`default_nettype wire

// *** common/swp_pkg.sv ***
package swp_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS        = 5;
   localparam int STATUS_WRITE_TIME_NS = 10000;
   localparam int STATUS_WRITE_CYCLES  =
      (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
   localparam logic [7:0] OP_ADDR4_ENTER   = 8'hB7;
   localparam logic [7:0] OP_ADDR4_EXIT    = 8'hE9;

   // ----------------------------------------------------------------
   // frame bit counts
   // ----------------------------------------------------------------
   localparam logic [5:0] BITS_OPCODE   = 6'h08;
   localparam logic [5:0] BITS_ONE_REG  = 6'h10;
   localparam logic [5:0] BITS_TWO_REG  = 6'h18;
   localparam logic [5:0] BITS_SAT      = 6'h3F;

   // ----------------------------------------------------------------
   // status and configuration field positions
   // ----------------------------------------------------------------
   localparam int SR_LOCK   = 7;
   localparam int SR_QUAD   = 6;
   localparam int SR_LVL_HI = 5;
   localparam int SR_LVL_LO = 2;
   localparam int SR_WEL    = 1;
   localparam int SR_BUSY   = 0;
   localparam int CR_DC_HI  = 7;
   localparam int CR_DC_LO  = 6;
   localparam int CR_ADDR4  = 5;
   localparam int CR_PBE    = 4;
   localparam int CR_TB     = 3;
   localparam int CR_DS_HI  = 1;
   localparam int CR_DS_LO  = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] RST_LEVEL = 4'h0;
   localparam logic [1:0] RST_DC    = 2'h0;
   localparam logic [1:0] RST_DS    = 2'h0;

   // ----------------------------------------------------------------
   // drive impedance and dummy clocks
   // ----------------------------------------------------------------
   localparam logic [6:0] OHM_DS00 = 7'h1E;
   localparam logic [6:0] OHM_DS01 = 7'h2D;
   localparam logic [6:0] OHM_DS10 = 7'h5A;
   localparam logic [6:0] OHM_DS11 = 7'h0F;
   localparam logic [3:0] DUMMY_4  = 4'h4;
   localparam logic [3:0] DUMMY_6  = 4'h6;
   localparam logic [3:0] DUMMY_8  = 4'h8;
   localparam logic [3:0] DUMMY_10 = 4'hA;

   typedef enum logic [2:0] {
      RK_FAST     = 3'b000,
      RK_DUAL_OUT = 3'b001,
      RK_QUAD_OUT = 3'b010,
      RK_DUAL_IO  = 3'b011,
      RK_QUAD_IO  = 3'b100
   } swp_read_kind_t;

   typedef enum logic [1:0] {
      FR_IDLE  = 2'b00,
      FR_SHIFT = 2'b01
   } swp_frame_t;
endpackage

// *** logic/swp_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module swp_sync
   import swp_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   // ----------------------------------------------------------------
   // two-stage synchroniser, first stage read only by the second
   // ----------------------------------------------------------------
   always_comb begin
      nxt_meta = async_i;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_o = sync_ff;
endmodule
`default_nettype wire

// *** logic/swp_write_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module swp_write_timer
   import swp_pkg::*;
#(
   parameter int CYCLES = STATUS_WRITE_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   output logic      busy_o,
   output logic      done_o
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_ff;
   logic          busy_ff;
   logic [CW-1:0] nxt_cnt;
   logic          nxt_busy;

   // ----------------------------------------------------------------
   // self-timed register write cycle
   // ----------------------------------------------------------------
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_busy = busy_ff;
      if (busy_ff) begin
         if (cnt_ff == LAST) begin
            nxt_busy = 1'b0;
            nxt_cnt  = '0;
         end else begin
            nxt_cnt = cnt_ff + CW'(1);
         end
      end else if (start_i) begin
         nxt_busy = 1'b1;
         nxt_cnt  = '0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end

   assign busy_o = busy_ff;
   // done in the last busy cycle, so registers, latch and busy change together
   assign done_o = busy_ff & (cnt_ff == LAST);
endmodule
`default_nettype wire

// *** tb/swp_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module swp_checker
   import swp_pkg::*;
#(
   parameter int WRITE_CYCLES = STATUS_WRITE_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       four_wire_command_mode_i,
   input  wire logic [7:0] status_reg_o,
   input  wire logic [7:0] config_reg_o,
   input  wire logic       hardware_protect_state_o,
   input  wire logic       software_protect_state_o,
   input  wire logic       shared_pins_are_data_o,
   input  wire logic [6:0] drive_ohms_o,
   input  wire logic       pe_refused_o,
   input  wire logic       write_status_cmd_rejected_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   // ----------------------------------------
   // busy length counter
   // ----------------------------------------
   always_comb begin
      nxt_cnt = status_reg_o[0] ? cnt_ff + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   function automatic logic [6:0] ohm_of(input logic [1:0] s);
      case (s)
         2'h0: return 7'h1E;
         2'h1: return 7'h2D;
         2'h2: return 7'h5A;
         default: return 7'h0F;
      endcase
   endfunction
   AST_OHMS: assert property (drive_ohms_o == ohm_of($past(config_reg_o[1:0])))
      else $error("drive impedance wrong");
   AST_WEL_NEEDED: assert property ($rose(status_reg_o[0]) |-> status_reg_o[1])
      else $error("write cycle started without latch");
   AST_HOLD: assert property (status_reg_o[0] && $past(status_reg_o[0])
      |-> $stable(status_reg_o[7:2]) && $stable(config_reg_o))
      else $error("registers changed mid write");
   AST_HPM_REFUSE: assert property (hardware_protect_state_o |-> !$rose(status_reg_o[0]))
      else $error("status write ran in hardware protect");
   AST_REJ: assert property (write_status_cmd_rejected_o |-> !$rose(status_reg_o[0]))
      else $error("rejected write started a cycle");
   AST_BUSY_LEN: assert property ($fell(status_reg_o[0]) |-> cnt_ff == 16'(WRITE_CYCLES))
      else $error("busy length wrong");
   AST_WEL_CLR: assert property ($fell(status_reg_o[0]) |-> !status_reg_o[1])
      else $error("latch not cleared at end");
   AST_HPM_LOCK: assert property (!status_reg_o[7] |-> !hardware_protect_state_o)
      else $error("hardware protect without lock");
   AST_SW: assert property (software_protect_state_o == !hardware_protect_state_o)
      else $error("protect states not exclusive");
   AST_QUAD_OFF: assert property (status_reg_o[6] || four_wire_command_mode_i
      |-> !hardware_protect_state_o)
      else $error("hardware protect not disabled");
   AST_PE: assert property ($past(status_reg_o[5:2]) == 4'h0 |-> !pe_refused_o)
      else $error("refused with no protect level");
   AST_PINS: assert property (shared_pins_are_data_o == status_reg_o[6])
      else $error("shared pin role wrong");
   COV_REJ: cover property (write_status_cmd_rejected_o);
   COV_WRITE: cover property ($fell(status_reg_o[0]));
   COV_HPM: cover property (hardware_protect_state_o);
   COV_PE: cover property (pe_refused_o);
endmodule
bind swp_status_ctrl swp_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
   .clk_i                    (clk_i),
   .rst_n_i                  (rst_n_i),
   .four_wire_command_mode_i (four_wire_command_mode_i),
   .status_reg_o             (status_reg_o),
   .config_reg_o             (config_reg_o),
   .hardware_protect_state_o (hardware_protect_state_o),
   .software_protect_state_o (software_protect_state_o),
   .shared_pins_are_data_o   (shared_pins_are_data_o),
   .drive_ohms_o             (drive_ohms_o),
   .pe_refused_o             (pe_refused_o),
   .write_status_cmd_rejected_o          (write_status_cmd_rejected_o)
);
`default_nettype wire

// *** tb/swp_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module swp_host_model (
   input  wire logic clk_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      data0_o,
   output logic      wp_n_o
);
   initial begin
      cs_n_o  = 1'b1;
      sclk_o  = 1'b0;
      data0_o = 1'b1;
      wp_n_o  = 1'b1;
   end
   task automatic half();
      #32;
   endtask
   // ----------------------------------------
   // msb first frame, clock idles low
   // ----------------------------------------
   task automatic frame(input logic [23:0] d, input int n);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         data0_o <= d[i];
         half();
         sclk_o <= 1'b1;
         half();
         sclk_o <= 1'b0;
      end
      half();
      cs_n_o  <= 1'b1;
      data0_o <= ~data0_o;
      half();
   endtask
   task automatic set_wp(input logic v);
      @(posedge clk_i);
      wp_n_o <= v;
      half();
   endtask
endmodule
`default_nettype wire

// *** tb/tb_swp_status_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_swp_status_ctrl
   import swp_pkg::*;
();
   localparam logic [3:0] QS [4] = '{4'h6, 4'h4, 4'h8, 4'hA};
   localparam logic [3:0] QD [4] = '{4'h6, 4'h6, 4'h8, 4'hA};
   localparam logic [6:0] OH [4] = '{7'h1E, 7'h2D, 7'h5A, 7'h0F};
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       fw;
   logic       dbl;
   logic [2:0] kind;
   logic       pe_req;
   logic [8:0] pe_blk;
   wire logic  cs_n, sclk, d0, wp_n;
   logic [7:0] sr, cr;
   logic [3:0] dum;
   logic [6:0] ohm;
   logic       hw, sw, shd, per, rej;
   int         err_count = 0;
   int         samples_checked = 0;
   int         rej_n = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) if (rej === 1'b1) rej_n++;
   swp_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .data0_o(d0), .wp_n_o(wp_n));
   swp_status_ctrl #(.WRITE_CYCLES(16)) dut (
      .clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk), .data0_i(d0),
      .write_protect_n_or_data2_i(wp_n), .four_wire_command_mode_i(fw),
      .double_edge_i(dbl), .read_kind_i(kind), .pe_req_i(pe_req), .pe_block_i(pe_blk),
      .status_reg_o(sr), .config_reg_o(cr), .hardware_protect_state_o(hw),
      .software_protect_state_o(sw), .shared_pins_are_data_o(shd), .dummy_clocks_o(dum),
      .drive_ohms_o(ohm), .pe_refused_o(per), .write_status_cmd_rejected_o(rej));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic write_enable_cmd();
      host.frame(24'(OP_WRITE_ENABLE), 8);
   endtask
   task automatic write_status_cmd(input logic [15:0] d, input int nb);
      host.frame(24'({OP_WRITE_STATUS, d}) >> (16 - nb), 8 + nb);
   endtask
   task automatic setreg(input logic [15:0] d, input int nb);
      write_enable_cmd();
      write_status_cmd(d, nb);
      chk(sr[0], 1'b1);
      for (int i = 0; i < 100 && sr[0] !== 1'b0; i++) @(posedge clk);
      @(posedge clk);
      chk(sr[1:0], 2'h0);
   endtask
   task automatic pe(input logic [8:0] b, input logic e);
      @(posedge clk);
      pe_blk <= b;
      pe_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk(per, e);
      pe_req <= 1'b0;
   endtask
   initial begin
      #200us;
      err_count++;
      test_done();
   end
   initial begin
      int n;
      fw     <= 1'b0;
      dbl    <= 1'b0;
      kind   <= 3'h0;
      pe_req <= 1'b0;
      pe_blk <= 9'h000;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk(sr, 8'h00);
      chk(cr, 8'h00);
      chk(ohm, 7'h1E);
      chk(dum, 4'h8);
      write_status_cmd(16'h3C00, 8);
      chk(rej_n, 1);
      chk(sr, 8'h00);
      write_enable_cmd();
      chk(sr, 8'h02);
      host.frame(24'(OP_WRITE_DISABLE), 8);
      write_status_cmd(16'h3C00, 8);
      chk(rej_n, 2);
      chk(sr, 8'h00);
      host.frame(24'(OP_ADDR4_ENTER), 8);
      chk(cr, 8'h20);
      host.frame(24'(OP_ADDR4_EXIT), 8);
      chk(cr, 8'h00);
      $display("test latch done");
      setreg(16'h3F00, 8);
      chk(sr, 8'h3C);
      chk(cr, 8'h00);
      host.set_wp(1'b0);
      setreg(16'h0700, 8);
      chk(sr, 8'h04);
      host.set_wp(1'b1);
      pe(9'h1FF, 1'b1);
      pe(9'h000, 1'b0);
      setreg(16'h0408, 16);
      chk(cr, 8'h08);
      pe(9'h000, 1'b1);
      pe(9'h1FF, 1'b0);
      $display("test protect area done");
      foreach (QS[b]) begin
         n = rej_n;
         write_enable_cmd();
         write_status_cmd(16'hFFFF, 9 + 2 * b);
         chk(rej_n, n + 1);
         chk(sr[7:2], 6'h01);
         chk(cr, 8'h08);
      end
      $display("test frame length done");
      for (int i = 0; i < 4; i++) begin
         setreg({8'h04, 2'(i), 4'h0, 2'(i)}, 16);
         chk(cr, {2'(i), 4'h2, 2'(i)});
         chk(ohm, OH[i]);
         for (int k = 0; k < 10; k++) begin
            kind <= 3'(k / 2);
            dbl  <= 1'(k);
            repeat (2) @(posedge clk);
            chk(dum, (k / 2 == 3) ? (i % 2 ? 4'h8 : 4'h4) : (k / 2 == 4) ?
                (k % 2 ? QD[i] : QS[i]) : 4'h8);
         end
      end
      $display("test dummy and drive done");
      setreg(16'h8400, 8);
      host.set_wp(1'b0);
      chk({hw, sw}, 2'h2);
      @(posedge clk);
      fw <= 1'b1;
      repeat (2) @(posedge clk);
      chk(hw, 1'b0);
      fw <= 1'b0;
      n = rej_n;
      write_enable_cmd();
      write_status_cmd(16'h0000, 8);
      chk(rej_n, n + 1);
      chk(sr[7:2], 6'h21);
      host.set_wp(1'b1);
      chk(hw, 1'b0);
      setreg(16'hC400, 8);
      chk(sr, 8'hC4);
      chk(shd, 1'b1);
      host.set_wp(1'b0);
      chk(hw, 1'b0);
      $display("test hardware protect done");
      test_done();
   end
endmodule
`default_nettype wire
